// >>> src/sctr_bank.sv
`timescale 1ns/1ns
// Functional notes
// (R1) coarse cap result bits 5:0, reset 0x20
// (R2) synth cal control bits 6:0, reset 0x0d
// (R3) registers from 0x29 lose contents in sleep
// (R4) trims 0x29..0x2b reset 0x59, 0x7f, 0x3f
// (R5) wake forces analog trim a 0x88/0x81
// (R6) analog trim a reads 0x88 after wake
// (R7) wake forces analog trim b 0x31/0x35
// (R8) analog trim b reads 0x31 after wake
// (R9) trim c bit1 enables vco select cal
// (R10) unused bits read zero, writes ignored
module sctr_bank
	import sctr_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// register port
	input  wire logic [5:0] reg_addr,
	input  wire logic       reg_write,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_read,
	output logic [7:0]      reg_rdata,
	output logic            reg_rvalid,
	// power state from the radio controller
	input  wire logic       sleep_active,
	input  wire logic       wake_up,
	input  wire logic       converter_retention_select,
	// analog side
	output logic [7:0]      vco_coarse_cap_result,
	output logic [7:0]      synth_cal_control,
	output logic [7:0]      reserved_trim_a,
	output logic [7:0]      reserved_trim_b,
	output logic [7:0]      reserved_trim_c,
	output logic [7:0]      analog_trim_a,
	output logic [7:0]      analog_trim_b,
	output logic [7:0]      analog_trim_c,
	output logic            vco_select_cal_enable
);
	// register file storage, indexed 0..7 in address order
	localparam int N_REG = 8;
	logic [7:0] reg_value [N_REG];   // host-visible contents
	logic [7:0] wr_sel;              // one-hot write strobes
	logic [7:0] force_sel;           // wake-up forcing strobes
	logic [7:0] force_val [N_REG];   // values loaded on wake-up
	logic [7:0] next_rdata;          // read mux result
	logic       next_rvalid;         // read answer strobe
	logic [7:0] next_analog_a;       // analog copy of trim a
	logic [7:0] next_analog_b;       // analog copy of trim b
	logic       lost;                // sleep-loss group contents unusable
	logic [7:0] next_vco_coarse_cap_result; // output stage next values
	logic [7:0] next_synth_cal_control;
	logic [7:0] next_reserved_trim_a;
	logic [7:0] next_reserved_trim_b;
	logic [7:0] next_reserved_trim_c;
	logic [7:0] next_analog_trim_a;
	logic [7:0] next_analog_trim_b;
	logic [7:0] next_analog_trim_c;
	logic       next_vco_select_cal_enable;

	// address to slot; unmapped addresses give no slot
	function automatic logic [7:0] sctr_decode(input logic [5:0] a);
		logic [7:0] s;
		s = 8'h00;
		case (a)
			SCTR_ADDR_VCO_COARSE_CAP_RESULT: s = 8'h01;
			SCTR_ADDR_SYNTH_CAL_CONTROL:     s = 8'h02;
			SCTR_ADDR_RESERVED_TRIM_A:       s = 8'h04;
			SCTR_ADDR_RESERVED_TRIM_B:       s = 8'h08;
			SCTR_ADDR_RESERVED_TRIM_C:       s = 8'h10;
			SCTR_ADDR_ANALOG_TRIM_A:         s = 8'h20;
			SCTR_ADDR_ANALOG_TRIM_B:         s = 8'h40;
			SCTR_ADDR_ANALOG_TRIM_C:         s = 8'h80;
			default:                         s = 8'h00;
		endcase
		return s;
	endfunction : sctr_decode

	// writes land only while awake
	always_comb
	begin
		wr_sel = (reg_write && !sleep_active) ? sctr_decode(reg_addr) : 8'h00;
	end

	// wake-up reloads the whole sleep-loss group with its reset image
	always_comb
	begin
		force_sel    = wake_up ? 8'hfc : 8'h00; // R3
		force_val[0] = SCTR_RST_VCO_COARSE_CAP_RESULT;
		force_val[1] = SCTR_RST_SYNTH_CAL_CONTROL;
		force_val[2] = SCTR_RST_RESERVED_TRIM_A; // R4
		force_val[3] = SCTR_RST_RESERVED_TRIM_B; // R4
		force_val[4] = SCTR_RST_RESERVED_TRIM_C; // R4
		force_val[5] = SCTR_RST_ANALOG_TRIM_A; // R6
		force_val[6] = SCTR_RST_ANALOG_TRIM_B; // R8
		force_val[7] = SCTR_RST_ANALOG_TRIM_C;
	end

	// the eight registers; masks keep unused bits at zero
	sctr_reg8 #(.RESET_VALUE(SCTR_RST_VCO_COARSE_CAP_RESULT),
		.WRITE_MASK(SCTR_MASK_VCO_COARSE_CAP_RESULT)) u_r0 ( // R1 R10
		.sys_clk(sys_clk), .rst(rst), .write_en(wr_sel[0]), .write_data(reg_wdata),
		.force_en(force_sel[0]), .force_data(force_val[0]), .value(reg_value[0]));
	sctr_reg8 #(.RESET_VALUE(SCTR_RST_SYNTH_CAL_CONTROL), .WRITE_MASK(SCTR_MASK_SYNTH_CAL_CONTROL)) u_r1 ( // R2 R10
		.sys_clk(sys_clk), .rst(rst), .write_en(wr_sel[1]), .write_data(reg_wdata),
		.force_en(force_sel[1]), .force_data(force_val[1]), .value(reg_value[1]));
	sctr_reg8 #(.RESET_VALUE(SCTR_RST_RESERVED_TRIM_A), .WRITE_MASK(SCTR_MASK_FULL)) u_r2 ( // R4
		.sys_clk(sys_clk), .rst(rst), .write_en(wr_sel[2]), .write_data(reg_wdata),
		.force_en(force_sel[2]), .force_data(force_val[2]), .value(reg_value[2]));
	sctr_reg8 #(.RESET_VALUE(SCTR_RST_RESERVED_TRIM_B), .WRITE_MASK(SCTR_MASK_FULL)) u_r3 ( // R4
		.sys_clk(sys_clk), .rst(rst), .write_en(wr_sel[3]), .write_data(reg_wdata),
		.force_en(force_sel[3]), .force_data(force_val[3]), .value(reg_value[3]));
	sctr_reg8 #(.RESET_VALUE(SCTR_RST_RESERVED_TRIM_C), .WRITE_MASK(SCTR_MASK_FULL)) u_r4 ( // R4
		.sys_clk(sys_clk), .rst(rst), .write_en(wr_sel[4]), .write_data(reg_wdata),
		.force_en(force_sel[4]), .force_data(force_val[4]), .value(reg_value[4]));
	sctr_reg8 #(.RESET_VALUE(SCTR_RST_ANALOG_TRIM_A), .WRITE_MASK(SCTR_MASK_FULL)) u_r5 (
		.sys_clk(sys_clk), .rst(rst), .write_en(wr_sel[5]), .write_data(reg_wdata),
		.force_en(force_sel[5]), .force_data(force_val[5]), .value(reg_value[5]));
	sctr_reg8 #(.RESET_VALUE(SCTR_RST_ANALOG_TRIM_B), .WRITE_MASK(SCTR_MASK_FULL)) u_r6 (
		.sys_clk(sys_clk), .rst(rst), .write_en(wr_sel[6]), .write_data(reg_wdata),
		.force_en(force_sel[6]), .force_data(force_val[6]), .value(reg_value[6]));
	sctr_reg8 #(.RESET_VALUE(SCTR_RST_ANALOG_TRIM_C), .WRITE_MASK(SCTR_MASK_FULL)) u_r7 (
		.sys_clk(sys_clk), .rst(rst), .write_en(wr_sel[7]), .write_data(reg_wdata),
		.force_en(force_sel[7]), .force_data(force_val[7]), .value(reg_value[7]));

	// read mux; unmapped addresses answer zero
	always_comb
	begin
		next_rdata  = 8'h00;
		next_rvalid = reg_read;
		case (sctr_decode(reg_addr))
			8'h01:   next_rdata = reg_value[0]; // R1
			8'h02:   next_rdata = reg_value[1]; // R2
			8'h04:   next_rdata = reg_value[2];
			8'h08:   next_rdata = reg_value[3];
			8'h10:   next_rdata = reg_value[4];
			8'h20:   next_rdata = reg_value[5]; // R6
			8'h40:   next_rdata = reg_value[6]; // R8
			8'h80:   next_rdata = reg_value[7];
			default: next_rdata = 8'h00; // R10
		endcase
		if (!reg_read)
			next_rdata = reg_rdata;
	end

	// read answer registers, one cycle after the request
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rdata  <= next_rdata;
			reg_rvalid <= next_rvalid;
		end
	end

	// analog copies of trim a and b; retention flips bits only here
	always_comb
	begin
		next_analog_a = analog_trim_a;
		next_analog_b = analog_trim_b;
		if (wake_up)
		begin
			next_analog_a = converter_retention_select ? SCTR_WAKE_ANALOG_TRIM_A_RET
			                                           : SCTR_RST_ANALOG_TRIM_A; // R5
			next_analog_b = converter_retention_select ? SCTR_WAKE_ANALOG_TRIM_B_RET
			                                           : SCTR_RST_ANALOG_TRIM_B; // R7
		end
		else if (wr_sel[5])
			next_analog_a = reg_wdata;
		else if (wr_sel[6])
			next_analog_b = reg_wdata;
	end

	// output stage next values; the sleep-loss group is parked at zero during sleep
	always_comb
	begin
		next_vco_coarse_cap_result = reg_value[0];
		next_synth_cal_control     = reg_value[1];
		next_reserved_trim_a       = lost ? 8'h00 : reg_value[2]; // R3
		next_reserved_trim_b       = lost ? 8'h00 : reg_value[3]; // R3
		next_reserved_trim_c       = lost ? 8'h00 : reg_value[4]; // R3
		next_analog_trim_a         = lost ? 8'h00 : next_analog_a; // R3
		next_analog_trim_b         = lost ? 8'h00 : next_analog_b; // R3
		next_analog_trim_c         = lost ? 8'h00 : reg_value[7]; // R3
		next_vco_select_cal_enable = !lost && reg_value[7][SCTR_BIT_VCO_SELECT_CAL_ENABLE]; // R9
	end

	// analog outputs; register stage only
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			vco_coarse_cap_result <= SCTR_RST_VCO_COARSE_CAP_RESULT;
			synth_cal_control     <= SCTR_RST_SYNTH_CAL_CONTROL;
			reserved_trim_a       <= SCTR_RST_RESERVED_TRIM_A;
			reserved_trim_b       <= SCTR_RST_RESERVED_TRIM_B;
			reserved_trim_c       <= SCTR_RST_RESERVED_TRIM_C;
			analog_trim_a         <= SCTR_RST_ANALOG_TRIM_A;
			analog_trim_b         <= SCTR_RST_ANALOG_TRIM_B;
			analog_trim_c         <= SCTR_RST_ANALOG_TRIM_C;
			vco_select_cal_enable <= SCTR_RST_ANALOG_TRIM_C[SCTR_BIT_VCO_SELECT_CAL_ENABLE];
		end
		else
		begin
			vco_coarse_cap_result <= next_vco_coarse_cap_result;
			synth_cal_control     <= next_synth_cal_control;
			reserved_trim_a       <= next_reserved_trim_a;
			reserved_trim_b       <= next_reserved_trim_b;
			reserved_trim_c       <= next_reserved_trim_c;
			analog_trim_a         <= next_analog_trim_a;
			analog_trim_b         <= next_analog_trim_b;
			analog_trim_c         <= next_analog_trim_c;
			vco_select_cal_enable <= next_vco_select_cal_enable;
		end
	end

	// sleep-loss group is treated as gone for as long as sleep lasts
	always_comb
	begin
		lost = sleep_active && !wake_up;
	end

	// wake-up reload leaves trim a readable as its reset value
	property p_trim_a_read_after_wake;
		@(posedge sys_clk) disable iff (rst)
		wake_up |=> (reg_value[5] == SCTR_RST_ANALOG_TRIM_A);
	endproperty
	a_trim_a_read_after_wake: assert property (p_trim_a_read_after_wake) else $error("trim a not 0x88 after wake"); // R6

	// wake-up reload leaves trim b readable as its reset value
	property p_trim_b_read_after_wake;
		@(posedge sys_clk) disable iff (rst)
		wake_up |=> (reg_value[6] == SCTR_RST_ANALOG_TRIM_B);
	endproperty
	a_trim_b_read_after_wake: assert property (p_trim_b_read_after_wake) else $error("trim b not 0x31 after wake"); // R8

	// analog copy of trim a follows the retention choice
	property p_analog_a_wake;
		@(posedge sys_clk) disable iff (rst)
		(wake_up && !sleep_active) |=>
		(analog_trim_a == ($past(converter_retention_select) ? SCTR_WAKE_ANALOG_TRIM_A_RET : SCTR_RST_ANALOG_TRIM_A));
	endproperty
	a_analog_a_wake: assert property (p_analog_a_wake) else $error("analog trim a wrong on wake"); // R5

	// analog copy of trim b follows the retention choice
	property p_analog_b_wake;
		@(posedge sys_clk) disable iff (rst)
		(wake_up && !sleep_active) |=>
		(analog_trim_b == ($past(converter_retention_select) ? SCTR_WAKE_ANALOG_TRIM_B_RET : SCTR_RST_ANALOG_TRIM_B));
	endproperty
	a_analog_b_wake: assert property (p_analog_b_wake) else $error("analog trim b wrong on wake"); // R7

	// unused bits of the coarse cap result never read as one
	property p_unused_zero;
		@(posedge sys_clk) disable iff (rst)
		reg_rvalid && $past(reg_addr) == SCTR_ADDR_VCO_COARSE_CAP_RESULT |-> reg_rdata[7:6] == 2'b00;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bits read as one"); // R10

	// control register write shows up masked on the analog side two edges later
	property p_cal_control_write;
		@(posedge sys_clk) disable iff (rst)
		(reg_write && !sleep_active && !wake_up && reg_addr == SCTR_ADDR_SYNTH_CAL_CONTROL) |=> ##1
		(synth_cal_control == {1'b0, $past(reg_wdata[6:0], 2)});
	endproperty
	a_cal_control_write: assert property (p_cal_control_write) else $error("cal control write lost"); // R2

	// sleep drops the test group outputs
	property p_sleep_loss;
		@(posedge sys_clk) disable iff (rst)
		(sleep_active && !wake_up) |=> (reserved_trim_a == 8'h00 && !vco_select_cal_enable);
	endproperty
	a_sleep_loss: assert property (p_sleep_loss) else $error("test group kept in sleep"); // R3

	// vco selection enable mirrors its stored bit while awake
	property p_vco_sel;
		@(posedge sys_clk) disable iff (rst)
		!sleep_active |=> vco_select_cal_enable == $past(reg_value[7][SCTR_BIT_VCO_SELECT_CAL_ENABLE]);
	endproperty
	a_vco_sel: assert property (p_vco_sel) else $error("vco select enable mismatch"); // R9

	// unmapped addresses answer zero on a read
	property p_unmapped_read_zero;
		@(posedge sys_clk) disable iff (rst)
		(reg_read && sctr_decode(reg_addr) == 8'h00) |=> (reg_rdata == 8'h00);
	endproperty
	a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read not zero"); // R10

	// writes during sleep leave the stored contents alone
	property p_sleep_write_refused;
		@(posedge sys_clk) disable iff (rst)
		(reg_write && sleep_active && !wake_up) |=>
		(reg_value[1] == $past(reg_value[1]) && reg_value[2] == $past(reg_value[2]));
	endproperty
	a_sleep_write_refused: assert property (p_sleep_write_refused) else $error("write landed in sleep"); // R3

	// calibration registers sit below the sleep-loss group and keep driving in sleep
	property p_cal_kept_in_sleep;
		@(posedge sys_clk) disable iff (rst)
		(sleep_active && !wake_up) |=> (synth_cal_control == $past(reg_value[1]));
	endproperty
	a_cal_kept_in_sleep: assert property (p_cal_kept_in_sleep) else $error("cal control dropped in sleep"); // R3

	// wake-up reloads the reserved trims with their reset values
	property p_reserved_wake;
		@(posedge sys_clk) disable iff (rst)
		wake_up |=> (reg_value[2] == SCTR_RST_RESERVED_TRIM_A && reg_value[3] == SCTR_RST_RESERVED_TRIM_B
		             && reg_value[4] == SCTR_RST_RESERVED_TRIM_C);
	endproperty
	a_reserved_wake: assert property (p_reserved_wake) else $error("reserved trims not reloaded on wake"); // R4

	// wake-up reloads trim c, so the vco selection stage is enabled again
	property p_trim_c_wake;
		@(posedge sys_clk) disable iff (rst)
		wake_up |=> (reg_value[7] == SCTR_RST_ANALOG_TRIM_C);
	endproperty
	a_trim_c_wake: assert property (p_trim_c_wake) else $error("trim c not reloaded on wake"); // R3
endmodule : sctr_bank

// >>> src/sctr_pkg.sv
package sctr_pkg;
	// register offsets within the configuration space
	localparam logic [5:0] SCTR_ADDR_VCO_COARSE_CAP_RESULT = 6'h25;
	localparam logic [5:0] SCTR_ADDR_SYNTH_CAL_CONTROL     = 6'h26;
	localparam logic [5:0] SCTR_ADDR_RESERVED_TRIM_A       = 6'h29;
	localparam logic [5:0] SCTR_ADDR_RESERVED_TRIM_B       = 6'h2a;
	localparam logic [5:0] SCTR_ADDR_RESERVED_TRIM_C       = 6'h2b;
	localparam logic [5:0] SCTR_ADDR_ANALOG_TRIM_A         = 6'h2c;
	localparam logic [5:0] SCTR_ADDR_ANALOG_TRIM_B         = 6'h2d;
	localparam logic [5:0] SCTR_ADDR_ANALOG_TRIM_C         = 6'h2e;
	// first address of the group that is lost in sleep
	localparam logic [5:0] SCTR_ADDR_SLEEP_LOSS_BASE       = 6'h29;

	// values after reset
	localparam logic [7:0] SCTR_RST_VCO_COARSE_CAP_RESULT = 8'h20;
	localparam logic [7:0] SCTR_RST_SYNTH_CAL_CONTROL     = 8'h0d;
	localparam logic [7:0] SCTR_RST_RESERVED_TRIM_A       = 8'h59;
	localparam logic [7:0] SCTR_RST_RESERVED_TRIM_B       = 8'h7f;
	localparam logic [7:0] SCTR_RST_RESERVED_TRIM_C       = 8'h3f;
	localparam logic [7:0] SCTR_RST_ANALOG_TRIM_A         = 8'h88;
	localparam logic [7:0] SCTR_RST_ANALOG_TRIM_B         = 8'h31;
	localparam logic [7:0] SCTR_RST_ANALOG_TRIM_C         = 8'h0b;

	// analog copies forced on wake-up when retention is selected
	localparam logic [7:0] SCTR_WAKE_ANALOG_TRIM_A_RET    = 8'h81;
	localparam logic [7:0] SCTR_WAKE_ANALOG_TRIM_B_RET    = 8'h35;

	// writable bit masks; zero bits are unused and read as zero
	localparam logic [7:0] SCTR_MASK_VCO_COARSE_CAP_RESULT = 8'h3f;
	localparam logic [7:0] SCTR_MASK_SYNTH_CAL_CONTROL     = 8'h7f;
	localparam logic [7:0] SCTR_MASK_FULL                  = 8'hff;

	// field position of the vco selection calibration enable
	localparam int SCTR_BIT_VCO_SELECT_CAL_ENABLE = 1;
endpackage : sctr_pkg

// >>> src/sctr_reg8.sv
`timescale 1ns/1ns
// one 8-bit configuration register with masked write and optional forced load
module sctr_reg8
	import sctr_pkg::*;
#(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK  = 8'hff
)(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// write and force
	input  wire logic       write_en,
	input  wire logic [7:0] write_data,
	input  wire logic       force_en,
	input  wire logic [7:0] force_data,
	// stored value
	output logic [7:0]      value
);
	logic [7:0] next_value; // value for the next edge

	// force has priority so a wake-up image is never half overwritten
	always_comb
	begin
		next_value = value;
		if (force_en)
			next_value = force_data & WRITE_MASK;
		else if (write_en)
			next_value = write_data & WRITE_MASK;
	end

	// plain register stage
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			value <= RESET_VALUE & WRITE_MASK;
		else
			value <= next_value;
	end
endmodule : sctr_reg8

// >>> testbench/sctr_bank_test.sv
`timescale 1ns/1ns
// bench: host model drives the port, reference arrays predict host reads and analog copies
module sctr_bank_test;
	import sctr_pkg::*;
	logic        sys_clk, rst, sleep_active, wake_up, converter_retention_select;
	logic [5:0]  reg_addr;
	logic        reg_write, reg_read, reg_rvalid, vco_select_cal_enable;
	logic [7:0]  reg_wdata, reg_rdata, d;
	logic [7:0]  out_v [0:7];   // analog copies in address order
	logic [7:0]  exp_rd [0:7];  // predicted host view
	logic [7:0]  exp_out [0:7]; // predicted analog view
	logic [31:0] rv;
	int          n_mismatch, n_checks, seed, i, r;
	logic [7:0]  rst_v [0:8] = '{8'h20, 8'h0d, 8'h59, 8'h7f, 8'h3f, 8'h88, 8'h31, 8'h0b, 8'h00};
	logic [7:0]  msk_v [0:7] = '{8'h3f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
	logic [5:0]  adr_v [0:8] = '{6'h25, 6'h26, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h27};

	sctr_host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_write(reg_write),
		.reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	sctr_bank dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
		.reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.sleep_active(sleep_active), .wake_up(wake_up), .converter_retention_select(converter_retention_select),
		.vco_coarse_cap_result(out_v[0]), .synth_cal_control(out_v[1]), .reserved_trim_a(out_v[2]),
		.reserved_trim_b(out_v[3]), .reserved_trim_c(out_v[4]), .analog_trim_a(out_v[5]),
		.analog_trim_b(out_v[6]), .analog_trim_c(out_v[7]), .vco_select_cal_enable(vco_select_cal_enable));

	// 25 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// verdict and end of run
	task automatic end_of_test;
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	// one comparison
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// read entry k (8 is the unmapped address) and compare with the host view
	task automatic rd_chk(input int k);
		logic ok;
		host_u.rd(adr_v[k], d, ok);
		if (!ok)
		begin
			n_mismatch++;
			$display("[FAIL] reg_rvalid expected 1 seen 0");
			end_of_test();
		end
		else
			chk("reg_rdata", (k == 8) ? 8'h00 : exp_rd[k], d);
	endtask : rd_chk
	// write entry k; unused bits are dropped in the prediction
	task automatic wr_m(input int k, input logic [7:0] v);
		host_u.wr(adr_v[k], v);
		exp_rd[k] = v & msk_v[k];
		exp_out[k] = exp_rd[k];
	endtask : wr_m
	// analog copies settle by one edge after the taking edge; the check waits two
	task automatic out_chk;
		int k;
		repeat (2) @(posedge sys_clk);
		#1;
		for (k = 0; k < 8; k++)
			chk("analog copy", exp_out[k], out_v[k]);
		chk("vco_select_cal_enable", {7'h00, exp_out[7][1]}, {7'h00, vco_select_cal_enable});
	endtask : out_chk
	// hang guard
	initial
	begin
		#400000;
		n_mismatch++;
		$display("[FAIL] run_time expected done seen timeout");
		end_of_test();
	end
	// main sequence
	initial
	begin
		seed = 32'h8311bef0;
		rst = 1'b1;
		sleep_active = 1'b0;
		wake_up = 1'b0;
		converter_retention_select = 1'b0;
		n_mismatch = 0;
		n_checks = 0;
		for (i = 0; i < 8; i++)
		begin
			exp_rd[i] = rst_v[i];
			exp_out[i] = rst_v[i];
		end
		repeat (16) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		out_chk();
		for (i = 0; i < 9; i++) rd_chk(i);
		host_u.wr(adr_v[8], 8'hff);
		for (i = 0; i < 8; i++) wr_m(i, 8'hff);
		out_chk();
		for (i = 0; i < 9; i++) rd_chk(i);
		for (r = 0; r < 2; r++)
		begin
			converter_retention_select = r[0];
			for (i = 0; i < 8; i++)
			begin
				rv = $random(seed);
				wr_m(i, rv[7:0]);
			end
			out_chk();
			for (i = 0; i < 8; i++) rd_chk(i);
			sleep_active = 1'b1;
			for (i = 0; i < 8; i++) host_u.wr(adr_v[i], ~exp_rd[i]);
			repeat (2) @(posedge sys_clk);
			#1;
			for (i = 2; i < 8; i++) chk("sleep copy", 8'h00, out_v[i]);
			for (i = 0; i < 2; i++) chk("sleep kept copy", exp_out[i], out_v[i]);
			chk("sleep vco enable", 8'h00, {7'h00, vco_select_cal_enable});
			for (i = 0; i < 8; i++) rd_chk(i);
			wake_up = 1'b1;
			sleep_active = 1'b0;
			@(posedge sys_clk);
			#1;
			wake_up = 1'b0;
			for (i = 2; i < 8; i++)
			begin
				exp_rd[i] = rst_v[i];
				exp_out[i] = rst_v[i];
			end
			if (r == 1)
			begin
				exp_out[5] = 8'h81;
				exp_out[6] = 8'h35;
			end
			repeat (1) @(posedge sys_clk);
			out_chk();
			for (i = 0; i < 8; i++) rd_chk(i);
		end
		// mid-run reset brings every register back, calibration ones too
		for (i = 0; i < 8; i++)
		begin
			exp_rd[i] = rst_v[i];
			exp_out[i] = rst_v[i];
		end
		rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		out_chk();
		for (i = 0; i < 9; i++) rd_chk(i);
		end_of_test();
	end
endmodule : sctr_bank_test

// >>> testbench/sctr_host_model.sv
`timescale 1ns/1ns
// host side of the register port; each call first lines up just after a rising edge
module sctr_host_model (
	// clock
	input  wire logic       sys_clk,
	// register port
	output logic [5:0]      reg_addr,
	output logic            reg_write,
	output logic [7:0]      reg_wdata,
	output logic            reg_read,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// idle port at time zero
	initial
	begin
		reg_addr = 6'h00;
		reg_write = 1'b0;
		reg_wdata = 8'h00;
		reg_read = 1'b0;
	end
	// one write, strobe held for exactly one edge
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_write = 1'b0;
		reg_wdata = ~d; // released data never shows the old value
	endtask : wr
	// one read; rvalid is looked for over a bounded number of edges
	task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
		int i;
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_read = 1'b0;
		ok = 1'b0;
		d = 8'h00;
		for (i = 0; i < 4 && !ok; i++)
		begin
			if (reg_rvalid === 1'b1)
			begin
				d = reg_rdata;
				ok = 1'b1;
			end
			else
			begin
				@(posedge sys_clk);
				#1;
			end
		end
	endtask : rd
endmodule : sctr_host_model
